/* File: logic/sps_regs.vh */
// Constants for the sleep and power-down sequencer
`ifndef SPS_REGS_VH
`define SPS_REGS_VH

// Channel layout: twelve enables plus the slow clock as lane 12
`define SPS_NCH 12
`define SPS_NLANE 13
`define SPS_SLOT_W 4
`define SPS_FINAL_SLOT 4'hf

// Timing
`define SPS_CLK_PERIOD_NS 25
`define SPS_SLOT_TIME_NS 1000
`define SPS_SLOT_CYC ((`SPS_SLOT_TIME_NS + `SPS_CLK_PERIOD_NS - 1) / `SPS_CLK_PERIOD_NS)
`define SPS_SLOT_DIV_W 6
`define SPS_SLOW_HALF_NS 15258
`define SPS_SLOW_HALF_CYC (`SPS_SLOW_HALF_NS / `SPS_CLK_PERIOD_NS)
`define SPS_SLOW_DIV_W 10
// Divider end values, sized to their counters so nothing is cut silently
`define SPS_SLOT_DIV_LAST 6'h27
`define SPS_SLOW_DIV_LAST 10'h261

// Sequencer states
`define SPS_ST_SHDN 4'h0
`define SPS_ST_PWRUP 4'h1
`define SPS_ST_RSTWAIT 4'h2
`define SPS_ST_ACTIVE 4'h3
`define SPS_ST_SLPENT 4'h4
`define SPS_ST_SLEEP 4'h5
`define SPS_ST_SLPEXIT 4'h6
`define SPS_ST_PWRDN 4'h7
`define SPS_ST_HALTRST 4'h8
`define SPS_ST_HALT 4'h9

// Fault flag bit positions
`define SPS_FLAG_THERMAL 0
`define SPS_FLAG_REGULATOR 1
`define SPS_FLAG_SELFTEST 2
`define SPS_FLAG_WATCHDOG 3
`define SPS_NFLAG 4

// Pin bit positions and idle levels
`define SPS_PIN_SLEEP 0
`define SPS_PIN_ACTIVE 1
`define SPS_PIN_BUTTON 2
`define SPS_PIN_RSTIN 3
`define SPS_PIN_EMPD 4
`define SPS_NPIN 5
`define SPS_PIN_IDLE 5'h1c

`endif

/* File: logic/sps_slot_timer.v */
// Slot timer: slot-period tick and running slot number
`include "sps_regs.vh"

module sps_slot_timer (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Restart at slot 1
  input wire start,
  // Tick at the end of each slot, with that slot's number
  output wire tick,
  output wire [`SPS_SLOT_W-1:0] slot
);

  localparam [`SPS_SLOT_DIV_W-1:0] DIV_LAST = `SPS_SLOT_DIV_LAST;

  reg [`SPS_SLOT_DIV_W-1:0] div_r;
  reg [`SPS_SLOT_W-1:0] slot_r;

  assign tick = (div_r == DIV_LAST);
  assign slot = slot_r;

  // Free running; slot number saturates so long waits stay valid
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= {`SPS_SLOT_DIV_W{1'b0}};
      slot_r <= 4'h1;
    end else if (start) begin
      div_r <= {`SPS_SLOT_DIV_W{1'b0}};
      slot_r <= 4'h1;
    end else if (tick) begin
      div_r <= {`SPS_SLOT_DIV_W{1'b0}};
      if (slot_r != `SPS_FINAL_SLOT) begin
        slot_r <= slot_r + 4'h1;
      end
    end else begin
      div_r <= div_r + {{(`SPS_SLOT_DIV_W-1){1'b0}}, 1'b1};
    end
  end

endmodule // sps_slot_timer

/* File: logic/sps_sequencer.v */
// Sleep, power-down and safe-halt sequencer core
`include "sps_regs.vh"

module sps_sequencer (
  // Clock and reset
  input wire SYS_CLK,
  input wire SYS_RESET_N,
  // Pins from outside the clock domain
  input wire SLEEP,
  input wire ACTIVE_REQUEST,
  input wire POWER_BUTTON_N,
  input wire RESET_REQUEST_IN_N,
  input wire EMERGENCY_POWERDOWN_IN_N,
  // Configuration
  input wire [`SPS_NCH*`SPS_SLOT_W-1:0] SLEEP_SLOT_CONFIG,
  input wire [`SPS_NCH*`SPS_SLOT_W-1:0] POWER_SLOT_CONFIG,
  input wire [`SPS_SLOT_W-1:0] SLOW_CLOCK_SLEEP_SLOT,
  input wire [`SPS_SLOT_W-1:0] SLOW_CLOCK_POWER_SLOT,
  input wire [`SPS_SLOT_W-1:0] RESET_RELEASE_DELAY,
  input wire [7:0] LONG_PRESS_THRESHOLD,
  input wire [1:0] FORCED_SHUTDOWN_FIELD,
  input wire POWER_BUTTON_ENABLE,
  input wire RESET_REQUEST_ENABLE,
  input wire EMERGENCY_POWERDOWN_ENABLE,
  input wire WATCHDOG_RESET_ENABLE,
  // Events from on-chip logic
  input wire RTC_ALARM,
  input wire FORCE_ACTIVE_CLEAR,
  input wire THERMAL_FAULT_EVENT,
  input wire REGULATOR_FAULT_EVENT,
  input wire SELFTEST_FAULT_EVENT,
  input wire WATCHDOG_VIOLATION_EVENT,
  input wire [`SPS_NFLAG-1:0] FLAG_CLEAR,
  // Supply side
  output wire [`SPS_NCH-1:0] ENABLE_OUTPUTS,
  output wire SLOW_CLOCK_OUTPUT,
  output wire RESET_OUTPUT_N,
  output wire IRQ_OUTPUT_N,
  // Status
  output wire [`SPS_NFLAG-1:0] FAULT_FLAGS,
  output wire FORCE_ACTIVE_BIT,
  output wire [3:0] SEQ_STATE
);

  localparam [`SPS_SLOW_DIV_W-1:0] SLOW_LAST = `SPS_SLOW_DIV_LAST;

  reg [`SPS_NPIN-1:0] pin_s1_r;
  reg [`SPS_NPIN-1:0] pin_s2_r;
  reg [`SPS_NPIN-1:0] pin_s3_r;
  reg [`SPS_NPIN-1:0] pin_f_r;
  reg [3:0] state_r;
  reg [`SPS_NLANE-1:0] lane_r;
  reg rst_n_r;
  reg irq_n_r;
  reg [`SPS_NFLAG-1:0] flags_r;
  reg force_active_bit_r;
  reg [7:0] press_cnt_r;
  reg long_press_r;
  reg tim_start_r;
  reg slow_clk_r;
  reg [`SPS_SLOW_DIV_W-1:0] slow_div_r;

  wire tick;
  wire [`SPS_SLOT_W-1:0] slot;
  wire [`SPS_NLANE*`SPS_SLOT_W-1:0] slp_cfg;
  wire [`SPS_NLANE*`SPS_SLOT_W-1:0] pwr_cfg;
  wire [`SPS_NLANE-1:0] slp_hit;
  wire [`SPS_NLANE-1:0] pwr_hit;
  wire [`SPS_NFLAG-1:0] flag_set;
  wire seq_done;
  wire rst_req;
  wire pd_req;
  wire fault;
  wire sleep_f;
  wire act_f;

  sps_slot_timer u_timer (
    .clk(SYS_CLK),
    .rst_n(SYS_RESET_N),
    .start(tim_start_r),
    .tick(tick),
    .slot(slot)
  );

  // Pins pass three flops; a change counts once stages two and three agree
  always @(posedge SYS_CLK or negedge SYS_RESET_N) begin
    if (!SYS_RESET_N) begin
      pin_s1_r <= `SPS_PIN_IDLE;
      pin_s2_r <= `SPS_PIN_IDLE;
      pin_s3_r <= `SPS_PIN_IDLE;
      pin_f_r <= `SPS_PIN_IDLE;
    end else begin
      pin_s1_r <= {EMERGENCY_POWERDOWN_IN_N, RESET_REQUEST_IN_N, POWER_BUTTON_N,
                   ACTIVE_REQUEST, SLEEP};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_f_r <= (pin_s2_r & pin_s3_r) | (pin_f_r & (pin_s2_r | pin_s3_r));
    end
  end

  assign sleep_f = pin_f_r[`SPS_PIN_SLEEP];
  assign act_f = pin_f_r[`SPS_PIN_ACTIVE];

  // Slow clock rides as the top lane with its own slot fields
  assign slp_cfg = {SLOW_CLOCK_SLEEP_SLOT, SLEEP_SLOT_CONFIG};
  assign pwr_cfg = {SLOW_CLOCK_POWER_SLOT, POWER_SLOT_CONFIG};

  // Per-lane slot match; slot zero never matches, so that lane is left alone
  genvar gi;
  generate
    for (gi = 0; gi < `SPS_NLANE; gi = gi + 1) begin : g_lane
      assign slp_hit[gi] = tick && (slp_cfg[gi*`SPS_SLOT_W +: `SPS_SLOT_W] == slot);
      assign pwr_hit[gi] = tick && (pwr_cfg[gi*`SPS_SLOT_W +: `SPS_SLOT_W] == slot);
    end
  endgenerate

  assign seq_done = tick && (slot == `SPS_FINAL_SLOT);

  // Reset demand: enabled pin, watchdog when selected, selftest always
  assign rst_req = (RESET_REQUEST_ENABLE && !pin_f_r[`SPS_PIN_RSTIN])
                   || (WATCHDOG_RESET_ENABLE && flags_r[`SPS_FLAG_WATCHDOG])
                   || flags_r[`SPS_FLAG_SELFTEST];

  // Power-down demand: long press, software field, emergency pin, active low
  assign pd_req = long_press_r || (FORCED_SHUTDOWN_FIELD != 2'h0)
                  || (EMERGENCY_POWERDOWN_ENABLE && !pin_f_r[`SPS_PIN_EMPD])
                  || !act_f;

  assign fault = flags_r[`SPS_FLAG_THERMAL] || flags_r[`SPS_FLAG_REGULATOR];

  assign flag_set = {WATCHDOG_VIOLATION_EVENT, SELFTEST_FAULT_EVENT,
                     REGULATOR_FAULT_EVENT, THERMAL_FAULT_EVENT};

  // Sticky flags: a new event beats a clear in the same cycle
  always @(posedge SYS_CLK or negedge SYS_RESET_N) begin
    if (!SYS_RESET_N) begin
      flags_r <= {`SPS_NFLAG{1'b0}};
      force_active_bit_r <= 1'b0;
    end else begin
      flags_r <= (flags_r & ~FLAG_CLEAR) | flag_set;
      force_active_bit_r <= RTC_ALARM || (force_active_bit_r && !FORCE_ACTIVE_CLEAR);
    end
  end

  // Press length counted in slot ticks; only a full threshold counts
  always @(posedge SYS_CLK or negedge SYS_RESET_N) begin
    if (!SYS_RESET_N) begin
      press_cnt_r <= 8'h00;
      long_press_r <= 1'b0;
    end else if (state_r == `SPS_ST_PWRDN) begin
      press_cnt_r <= 8'h00;
      long_press_r <= 1'b0;
    end else if (POWER_BUTTON_ENABLE && !pin_f_r[`SPS_PIN_BUTTON]) begin
      if (tick && press_cnt_r != 8'hff) begin
        press_cnt_r <= press_cnt_r + 8'h01;
      end
      if (LONG_PRESS_THRESHOLD != 8'h00 && press_cnt_r >= LONG_PRESS_THRESHOLD) begin
        long_press_r <= 1'b1;
      end
    end else begin
      press_cnt_r <= 8'h00;
    end
  end

  // Sequencer; triggers other than a fault are only looked at in settled states,
  // so any that arrive mid-sequence simply wait for the final slot
  always @(posedge SYS_CLK or negedge SYS_RESET_N) begin
    if (!SYS_RESET_N) begin
      state_r <= `SPS_ST_SHDN;
      lane_r <= {`SPS_NLANE{1'b0}};
      rst_n_r <= 1'b0;
      tim_start_r <= 1'b0;
    end else begin
      tim_start_r <= 1'b0;
      if (fault && state_r != `SPS_ST_HALTRST && state_r != `SPS_ST_HALT) begin
        // Safety first: no waiting for the current sequence
        state_r <= `SPS_ST_HALTRST;
        rst_n_r <= 1'b0;
      end else begin
        case (state_r)
          `SPS_ST_SHDN: begin
            rst_n_r <= 1'b0;
            if (act_f && !pd_req) begin
              state_r <= `SPS_ST_PWRUP;
              tim_start_r <= 1'b1;
            end
          end
          `SPS_ST_PWRUP: begin
            lane_r <= lane_r | pwr_hit;
            if (seq_done) begin
              state_r <= `SPS_ST_RSTWAIT;
              tim_start_r <= 1'b1;
            end
          end
          `SPS_ST_RSTWAIT: begin
            if (pd_req) begin
              state_r <= `SPS_ST_PWRDN;
              tim_start_r <= 1'b1;
            end else if (rst_req) begin
              tim_start_r <= 1'b1;
            end else if (tick && slot >= RESET_RELEASE_DELAY) begin
              rst_n_r <= 1'b1;
              state_r <= `SPS_ST_ACTIVE;
            end
          end
          `SPS_ST_ACTIVE: begin
            if (rst_req) begin
              rst_n_r <= 1'b0;
              state_r <= `SPS_ST_RSTWAIT;
              tim_start_r <= 1'b1;
            end else if (pd_req) begin
              state_r <= `SPS_ST_PWRDN;
              tim_start_r <= 1'b1;
            end else if (!sleep_f) begin
              state_r <= `SPS_ST_SLPENT;
              tim_start_r <= 1'b1;
            end
          end
          `SPS_ST_SLPENT: begin
            lane_r <= lane_r & ~slp_hit;
            if (seq_done) begin
              state_r <= `SPS_ST_SLEEP;
            end
          end
          `SPS_ST_SLEEP: begin
            if (pd_req) begin
              state_r <= `SPS_ST_PWRDN;
              tim_start_r <= 1'b1;
            end else if (sleep_f || force_active_bit_r || rst_req) begin
              state_r <= `SPS_ST_SLPEXIT;
              tim_start_r <= 1'b1;
              if (rst_req) begin
                rst_n_r <= 1'b0;
              end
            end
          end
          `SPS_ST_SLPEXIT: begin
            lane_r <= lane_r | slp_hit;
            if (seq_done) begin
              // Reset asserted on the way out: wait the release delay
              state_r <= rst_n_r ? `SPS_ST_ACTIVE : `SPS_ST_RSTWAIT;
              tim_start_r <= !rst_n_r;
            end
          end
          `SPS_ST_PWRDN: begin
            if (tick && slot == 4'h1) begin
              rst_n_r <= 1'b0;
            end
            // Lanes already dropped by sleep entry just stay low
            lane_r <= lane_r & ~pwr_hit;
            if (seq_done) begin
              state_r <= `SPS_ST_SHDN;
            end
          end
          `SPS_ST_HALTRST: begin
            // Reset went low last cycle; now the rest follows
            lane_r <= {`SPS_NLANE{1'b0}};
            state_r <= `SPS_ST_HALT;
          end
          `SPS_ST_HALT: begin
            // Terminal until power cycle; pins ignored
            lane_r <= {`SPS_NLANE{1'b0}};
            rst_n_r <= 1'b0;
          end
          default: begin
            state_r <= `SPS_ST_SHDN;
          end
        endcase
      end
    end
  end

  // Interrupt: any sticky flag or pending wake; forced low in halt
  always @(posedge SYS_CLK or negedge SYS_RESET_N) begin
    if (!SYS_RESET_N) begin
      irq_n_r <= 1'b1;
    end else if (state_r == `SPS_ST_HALT) begin
      irq_n_r <= 1'b0;
    end else begin
      irq_n_r <= !((|flags_r) || force_active_bit_r);
    end
  end

  // Slow clock divider, gated by its lane; parks low when gated
  always @(posedge SYS_CLK or negedge SYS_RESET_N) begin
    if (!SYS_RESET_N) begin
      slow_div_r <= {`SPS_SLOW_DIV_W{1'b0}};
      slow_clk_r <= 1'b0;
    end else if (!lane_r[`SPS_NCH]) begin
      slow_div_r <= {`SPS_SLOW_DIV_W{1'b0}};
      slow_clk_r <= 1'b0;
    end else if (slow_div_r == SLOW_LAST) begin
      slow_div_r <= {`SPS_SLOW_DIV_W{1'b0}};
      slow_clk_r <= !slow_clk_r;
    end else begin
      slow_div_r <= slow_div_r + {{(`SPS_SLOW_DIV_W-1){1'b0}}, 1'b1};
    end
  end

  assign ENABLE_OUTPUTS = lane_r[`SPS_NCH-1:0];
  assign SLOW_CLOCK_OUTPUT = slow_clk_r;
  assign RESET_OUTPUT_N = rst_n_r;
  assign IRQ_OUTPUT_N = irq_n_r;
  assign FAULT_FLAGS = flags_r;
  assign FORCE_ACTIVE_BIT = force_active_bit_r;
  assign SEQ_STATE = state_r;

endmodule // sps_sequencer

/* File: verif/sps_seq_assertions.sv */
// Checker for the sleep and power-down sequencer
`include "sps_regs.vh"
module sps_seq_checker (
  // Clock and reset
  input wire SYS_CLK,
  input wire SYS_RESET_N,
  // Configuration and clears
  input wire [47:0] SLEEP_SLOT_CONFIG,
  input wire [47:0] POWER_SLOT_CONFIG,
  input wire [3:0] FLAG_CLEAR,
  // Supply side and status
  input wire [11:0] ENABLE_OUTPUTS,
  input wire SLOW_CLOCK_OUTPUT,
  input wire RESET_OUTPUT_N,
  input wire IRQ_OUTPUT_N,
  input wire [3:0] FAULT_FLAGS,
  input wire FORCE_ACTIVE_BIT,
  input wire [3:0] SEQ_STATE
);
  timeunit 1ns;
  timeprecision 100ps;
  reg [3:0] keep_r;
  reg [3:0] st_r;
  reg [11:0] slp_m;
  reg [11:0] pwr_m;
  integer i;
  // Flags that must survive, kept as a signal so no expression goes into $past
  always @(posedge SYS_CLK or negedge SYS_RESET_N) begin
    if (!SYS_RESET_N) begin
      keep_r <= 4'h0;
      st_r <= 4'h0;
    end else begin
      keep_r <= FAULT_FLAGS & ~FLAG_CLEAR;
      st_r <= SEQ_STATE;
    end
  end
  // Lanes that each sequence may touch
  always @* begin
    for (i = 0; i < 12; i = i + 1) begin
      slp_m[i] = |SLEEP_SLOT_CONFIG[4*i +: 4];
      pwr_m[i] = |POWER_SLOT_CONFIG[4*i +: 4];
    end
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!SYS_RESET_N);
  sequence halt_in_s;
    SEQ_STATE == `SPS_ST_HALTRST ##1 SEQ_STATE == `SPS_ST_HALT;
  endsequence
  sleep_lanes_off_a: assert property (st_r == `SPS_ST_SLPENT && SEQ_STATE == `SPS_ST_SLEEP
    |-> (ENABLE_OUTPUTS & slp_m) == 12'h000) else $error("sleep lanes still on");
  pdn_lanes_off_a: assert property (st_r == `SPS_ST_PWRDN && SEQ_STATE == `SPS_ST_SHDN
    |-> (ENABLE_OUTPUTS & pwr_m) == 12'h000) else $error("power lanes still on");
  pdn_reset_low_a: assert property (SEQ_STATE == `SPS_ST_PWRDN && st_r != `SPS_ST_PWRDN
    |-> ##[1:45] !RESET_OUTPUT_N) else $error("reset late in power-down");
  fault_to_halt_a: assert property ((FAULT_FLAGS[0] | FAULT_FLAGS[1]) && SEQ_STATE != 4'h9
    |-> ##[0:1] SEQ_STATE == `SPS_ST_HALTRST) else $error("fault did not halt");
  halt_order_a: assert property (SEQ_STATE == `SPS_ST_HALTRST && st_r != `SPS_ST_HALTRST
    |-> !RESET_OUTPUT_N ##0 halt_in_s ##1 (ENABLE_OUTPUTS == 12'h000 && !SLOW_CLOCK_OUTPUT))
    else $error("halt order wrong");
  halt_hold_a: assert property (SEQ_STATE == `SPS_ST_HALT
    |=> SEQ_STATE == `SPS_ST_HALT && !IRQ_OUTPUT_N) else $error("halt left");
  flag_sticky_a: assert property ((FAULT_FLAGS & keep_r) == keep_r)
    else $error("flag lost");
  irq_follow_a: assert property (st_r != `SPS_ST_HALT
    |-> IRQ_OUTPUT_N == !((|$past(FAULT_FLAGS)) || $past(FORCE_ACTIVE_BIT)))
    else $error("irq wrong");
  selftest_rst_a: assert property (SEQ_STATE == `SPS_ST_ACTIVE && FAULT_FLAGS == 4'h4
    |=> SEQ_STATE == `SPS_ST_RSTWAIT && !RESET_OUTPUT_N) else $error("selftest no reset");
endmodule // sps_seq_checker
bind sps_sequencer sps_seq_checker chk_u (.SYS_CLK(SYS_CLK), .SYS_RESET_N(SYS_RESET_N),
  .SLEEP_SLOT_CONFIG(SLEEP_SLOT_CONFIG), .POWER_SLOT_CONFIG(POWER_SLOT_CONFIG),
  .FLAG_CLEAR(FLAG_CLEAR), .ENABLE_OUTPUTS(ENABLE_OUTPUTS),
  .SLOW_CLOCK_OUTPUT(SLOW_CLOCK_OUTPUT), .RESET_OUTPUT_N(RESET_OUTPUT_N),
  .IRQ_OUTPUT_N(IRQ_OUTPUT_N), .FAULT_FLAGS(FAULT_FLAGS),
  .FORCE_ACTIVE_BIT(FORCE_ACTIVE_BIT), .SEQ_STATE(SEQ_STATE));

/* File: verif/sps_host_model.sv */
// Host model: answers an alarm wake by raising sleep, then clearing the wake bit
module sps_host_model (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // From the sequencer
  input wire irq_n,
  input wire force_bit,
  // Bench command and pins to the sequencer
  input wire sleep_cmd,
  output reg sleep_o,
  output reg fa_clr_o
);
  timeunit 1ns;
  timeprecision 100ps;
  reg woke_r;
  // Clear only after sleep is already high, so the wake is never dropped
  always @(negedge clk or negedge rst_n) begin
    if (!rst_n) begin
      woke_r <= 1'b0;
      sleep_o <= 1'b0;
      fa_clr_o <= 1'b0;
    end else begin
      if (!irq_n && force_bit)
        woke_r <= 1'b1;
      else if (sleep_cmd)
        woke_r <= 1'b0;
      sleep_o <= sleep_cmd | woke_r;
      fa_clr_o <= sleep_o && woke_r && force_bit;
    end
  end
endmodule // sps_host_model

/* File: verif/sleep_powerdown_sequencer_test.sv */
// Testbench for the sleep and power-down sequencer
`include "sps_regs.vh"
`define SPS_CHK(a, b) begin n_tests = n_tests + 1; if ((a) !== (b)) begin fails = fails + 1; \
  $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module sleep_powerdown_sequencer_test;
  timeunit 1ns;
  timeprecision 100ps;
  reg clk, rst_n, act, scmd, rstin_n, rre, wdre, rtc, selft, wdog;
  reg btn_n, pbe, empd_n, epe, sref;
  reg [7:0] lpt;
  reg [1:0] flt;
  reg [1:0] fsd;
  reg [3:0] fclr;
  reg [3:0] dly;
  reg [7:0] sck;
  reg [47:0] scfg;
  reg [47:0] pcfg;
  wire [11:0] en;
  wire [3:0] flags;
  wire [3:0] st;
  wire sclk, rst_o_n, irq_n, fab, sleep, faclr;
  integer fails, n_tests, k;
  sps_sequencer dut_u (.SYS_CLK(clk), .SYS_RESET_N(rst_n), .SLEEP(sleep),
    .ACTIVE_REQUEST(act), .POWER_BUTTON_N(btn_n), .RESET_REQUEST_IN_N(rstin_n),
    .EMERGENCY_POWERDOWN_IN_N(empd_n), .SLEEP_SLOT_CONFIG(scfg), .POWER_SLOT_CONFIG(pcfg),
    .SLOW_CLOCK_SLEEP_SLOT(sck[7:4]), .SLOW_CLOCK_POWER_SLOT(sck[3:0]),
    .RESET_RELEASE_DELAY(dly), .LONG_PRESS_THRESHOLD(lpt), .FORCED_SHUTDOWN_FIELD(fsd),
    .POWER_BUTTON_ENABLE(pbe), .RESET_REQUEST_ENABLE(rre), .EMERGENCY_POWERDOWN_ENABLE(epe),
    .WATCHDOG_RESET_ENABLE(wdre), .RTC_ALARM(rtc), .FORCE_ACTIVE_CLEAR(faclr),
    .THERMAL_FAULT_EVENT(flt[0]), .REGULATOR_FAULT_EVENT(flt[1]),
    .SELFTEST_FAULT_EVENT(selft), .WATCHDOG_VIOLATION_EVENT(wdog), .FLAG_CLEAR(fclr),
    .ENABLE_OUTPUTS(en), .SLOW_CLOCK_OUTPUT(sclk), .RESET_OUTPUT_N(rst_o_n),
    .IRQ_OUTPUT_N(irq_n), .FAULT_FLAGS(flags), .FORCE_ACTIVE_BIT(fab), .SEQ_STATE(st));
  sps_host_model host_u (.clk(clk), .rst_n(rst_n), .irq_n(irq_n), .force_bit(fab),
    .sleep_cmd(scmd), .sleep_o(sleep), .fa_clr_o(faclr));
  // Free-running system clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task end_of_test;
    begin
      $display("compares %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  // Bounded wait for a state, sampled at the falling edge
  task wait_st(input [3:0] s);
    begin
      k = 0;
      while (st !== s && k < 3000) begin
        @(negedge clk);
        k = k + 1;
      end
      `SPS_CHK(st, s)
    end
  endtask
  task t_sleep_entry;
    begin
      scmd = 1'b0;
      wait_st(`SPS_ST_SLPENT);
      k = 0;
      while (en[0] !== 1'b0 && k < 100) begin
        @(negedge clk);
        k = k + 1;
      end
      `SPS_CHK(k, 41)
      wait_st(`SPS_ST_SLEEP);
      `SPS_CHK(en, 12'hfc0)
      `SPS_CHK(sclk, 1'b0)
      $display("sleep entry done");
    end
  endtask
  task t_rtc_wake;
    begin
      rtc = 1'b1;
      @(negedge clk);
      rtc = 1'b0;
      wait_st(`SPS_ST_ACTIVE);
      `SPS_CHK(en, 12'hfff)
      `SPS_CHK(fab, 1'b0)
      `SPS_CHK(irq_n, 1'b1)
      scmd = 1'b1;
      $display("alarm wake done");
    end
  endtask
  task t_flags;
    begin
      wdog = 1'b1;
      @(negedge clk);
      wdog = 1'b0;
      repeat (3) @(negedge clk);
      `SPS_CHK(irq_n, 1'b0)
      `SPS_CHK(rst_o_n, 1'b1)
      fclr = 4'h8;
      @(negedge clk);
      fclr = 4'h0;
      repeat (3) @(negedge clk);
      `SPS_CHK({irq_n, flags}, 5'h10)
      selft = 1'b1;
      @(negedge clk);
      selft = 1'b0;
      repeat (3) @(negedge clk);
      `SPS_CHK({rst_o_n, irq_n, st}, {2'b00, `SPS_ST_RSTWAIT})
      fclr = 4'h4;
      @(negedge clk);
      fclr = 4'h0;
      wait_st(`SPS_ST_ACTIVE);
      repeat (2) @(negedge clk);
      `SPS_CHK(rst_o_n, 1'b1)
      $display("fault flags done");
    end
  endtask
  task t_pdown_sleep;
    begin
      t_sleep_entry;
      fsd = 2'h1;
      wait_st(`SPS_ST_PWRDN);
      repeat (45) @(negedge clk);
      `SPS_CHK(rst_o_n, 1'b0)
      // Power-up demand mid power-down must wait for the last slot
      scmd = 1'b1;
      fsd = 2'h0;
      repeat (100) @(negedge clk);
      `SPS_CHK(st, `SPS_ST_PWRDN)
      wait_st(`SPS_ST_SHDN);
      `SPS_CHK(en, 12'h000)
      wait_st(`SPS_ST_ACTIVE);
      `SPS_CHK(en, 12'hfff)
      $display("power-down from sleep done");
    end
  endtask
  task t_halt;
    begin
      flt = 2'h3;
      @(negedge clk);
      flt = 2'h0;
      wait_st(`SPS_ST_HALT);
      `SPS_CHK(rst_o_n, 1'b0)
      repeat (2) @(negedge clk);
      `SPS_CHK({en, sclk, irq_n}, 14'h0000)
      `SPS_CHK(flags[1:0], 2'h3)
      act = 1'b0;
      scmd = 1'b0;
      repeat (10) @(negedge clk);
      `SPS_CHK(st, `SPS_ST_HALT)
      $display("safe halt done");
    end
  endtask
  // Reset pin while asleep: exit under reset, release after pin and delay
  task t_rst_sleep;
    begin
      t_sleep_entry;
      rstin_n = 1'b0;
      wait_st(`SPS_ST_SLPEXIT);
      `SPS_CHK(rst_o_n, 1'b0)
      wait_st(`SPS_ST_RSTWAIT);
      repeat (100) @(negedge clk);
      `SPS_CHK({en, rst_o_n, st}, {12'hfff, 1'b0, `SPS_ST_RSTWAIT})
      rstin_n = 1'b1;
      scmd = 1'b1;
      k = 0;
      while (rst_o_n !== 1'b1 && k < 100) begin
        @(negedge clk);
        k = k + 1;
      end
      // Four sync edges, restart edge, then one slot period
      `SPS_CHK(k, 45)
      $display("reset request in sleep done");
    end
  endtask
  task t_wdog_sleep;
    begin
      wdre = 1'b1;
      t_sleep_entry;
      wdog = 1'b1;
      @(negedge clk);
      wdog = 1'b0;
      wait_st(`SPS_ST_SLPEXIT);
      `SPS_CHK({rst_o_n, irq_n}, 2'b00)
      wait_st(`SPS_ST_RSTWAIT);
      `SPS_CHK({en, rst_o_n}, 13'h1ffe)
      scmd = 1'b1;
      fclr = 4'h8;
      @(negedge clk);
      fclr = 4'h0;
      wait_st(`SPS_ST_ACTIVE);
      `SPS_CHK({rst_o_n, irq_n}, 2'b11)
      wdre = 1'b0;
      $display("watchdog reset in sleep done");
    end
  endtask
  // Short press stays below threshold; a held press powers down
  task t_long_press;
    begin
      pbe = 1'b1;
      lpt = 8'h03;
      btn_n = 1'b0;
      repeat (60) @(negedge clk);
      btn_n = 1'b1;
      repeat (10) @(negedge clk);
      `SPS_CHK(st, `SPS_ST_ACTIVE)
      btn_n = 1'b0;
      wait_st(`SPS_ST_PWRDN);
      // Three slot ticks, first one up to a slot after the press is seen
      `SPS_CHK((k >= 87) && (k <= 126), 1'b1)
      btn_n = 1'b1;
      wait_st(`SPS_ST_SHDN);
      `SPS_CHK(en, 12'h000)
      pbe = 1'b0;
      wait_st(`SPS_ST_ACTIVE);
      `SPS_CHK(en, 12'hfff)
      $display("long press power-down done");
    end
  endtask
  task t_emerg;
    begin
      epe = 1'b1;
      empd_n = 1'b0;
      wait_st(`SPS_ST_PWRDN);
      `SPS_CHK(k, 5)
      empd_n = 1'b1;
      epe = 1'b0;
      wait_st(`SPS_ST_ACTIVE);
      `SPS_CHK({en, rst_o_n}, 13'h1fff)
      $display("emergency pin power-down done");
    end
  endtask
  // Hang guard, about twice the ten thousand cycles the tests need
  initial begin
    #500000;
    fails = fails + 1;
    end_of_test;
  end
  // Main sequence
  initial begin
    {rst_n, rtc, selft, wdog, wdre, flt, fsd, fclr} = 0;
    {act, scmd, rstin_n, rre} = 4'hf;
    {btn_n, empd_n, pbe, epe} = 4'hc;
    lpt = 8'h00;
    fails = 0;
    n_tests = 0;
    dly = 4'h1;
    sck = 8'h2d;
    scfg = 48'h000000654321;
    pcfg = 48'hcba987654321;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    wait_st(`SPS_ST_ACTIVE);
    `SPS_CHK({en, rst_o_n}, 13'h1fff)
    // Slow clock level flips across one half-period window after reaching active
    sref = sclk;
    repeat (`SPS_SLOW_HALF_CYC) @(negedge clk);
    `SPS_CHK(sclk, !sref)
    t_sleep_entry;
    t_rtc_wake;
    t_flags;
    t_pdown_sleep;
    t_rst_sleep;
    t_wdog_sleep;
    t_long_press;
    t_emerg;
    t_halt;
    end_of_test;
  end
endmodule // sleep_powerdown_sequencer_test
